// >>> core/tcw_decoder.sv
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module tcw_decoder (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             wr_valid_i,
    input  wire logic [31:0]      wr_data_i,
    output var  tcw_pkg::tcw_beat_t beat_o,
    output var  tcw_pkg::tcw_info_t pkt_info_o,
    output logic                  pkt_start_o,
    output logic                  irq_o,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic [31:0]           wb_dat_o,
    output logic                  wb_ack_o
);
    import tcw_pkg::*;

    tcw_state_t  state_q, state_d;
    tcw_cmd_a_t  a_q;
    tcw_cmd_b_t  b_q;
    logic [9:0]  words_q;    // dwords in the buffer incl. offset and pad
    logic [9:0]  widx_q;     // dword index within the buffer
    logic [11:0] acc_q;      // summed buffer counts of the packet
    logic [11:0] rcv_q;      // payload bytes really seen
    logic        ctrl_q;
    logic [1:0]  sts_q;
    logic [1:0]  msk_q;
    tcw_beat_t   beat_q;
    tcw_info_t   info_q;
    logic        start_q;
    logic        irq_q;
    logic [31:0] rdat_q;
    logic        ack_q;

    // incoming words seen as either command layout
    tcw_cmd_a_t a_in;
    tcw_cmd_b_t b_in;
    assign a_in = tcw_cmd_a_t'(wr_data_i);
    assign b_in = tcw_cmd_b_t'(wr_data_i);

    wire take_a = wr_valid_i && (state_q == ST_CMD_A);
    wire take_b = wr_valid_i && (state_q == ST_CMD_B);
    wire take_d = wr_valid_i && (state_q == ST_DATA);

    // pad boundary mask; the reserved code is treated as 4-byte so the
    // stream stays in step, while the error flag reports it
    wire [11:0] amask = (a_in.align == ALIGN_16) ? AMASK_16 :
                        (a_in.align == ALIGN_32) ? AMASK_32 : AMASK_4;
    wire [11:0] span  = 12'(a_in.offset) + 12'(a_in.size);
    wire [11:0] rnd   = span + amask;
    wire [9:0]  words_in = rnd[11:2] & ~{7'h00, amask[4:2]};
    wire        bad_align = take_a && (a_in.align == ALIGN_BAD);

    // byte lane valid when offset <= position < offset + size
    wire [11:0] b_lo = 12'(a_q.offset);
    wire [11:0] b_hi = 12'(a_q.offset) + 12'(a_q.size);
    logic [3:0] lane_ok;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            wire [11:0] pos = {widx_q, 2'b00} + 12'(g);
            assign lane_ok[g] = (pos >= b_lo) && (pos < b_hi);
        end
    endgenerate
    wire [2:0] pop = 3'(lane_ok[0]) + 3'(lane_ok[1])
                   + 3'(lane_ok[2]) + 3'(lane_ok[3]);

    // end of a buffer: last dword taken, or an empty buffer after command b
    wire last_w  = take_d && (widx_q == words_q - 10'h001);
    wire buf_end = last_w || (take_b && words_q == 10'h000);
    wire [11:0] rcv_nx = rcv_q + (take_d ? 12'(pop) : 12'h000);
    wire pkt_end = buf_end && a_q.last_seg;

    // error sources
    // an empty buffer ends at its own command b, before b_q holds it
    wire [11:0] len_now = 12'(take_b ? b_in.pkt_len : b_q.pkt_len);
    wire b_diff  = take_b && !a_q.first_seg && (b_in != b_q);
    wire len_bad = pkt_end && (acc_q != len_now);
    wire rcv_bad = pkt_end && (rcv_nx != len_now);
    wire ev_err  = bad_align || b_diff || len_bad || rcv_bad;
    wire ev_done = buf_end && a_q.ioc;

    // next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_CMD_A: if (wr_valid_i) state_d = ST_CMD_B;
            ST_CMD_B: if (wr_valid_i) state_d = (words_q == 10'h000) ? ST_CMD_A : ST_DATA;
            ST_DATA:  if (last_w) state_d = ST_CMD_A;
            default:  state_d = ST_CMD_A;
        endcase
    end

    // command capture and buffer bookkeeping
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_CMD_A;
            a_q     <= '0;
            b_q     <= '0;
            words_q <= 10'h000;
            widx_q  <= 10'h000;
            acc_q   <= 12'h000;
            rcv_q   <= 12'h000;
        end else begin
            state_q <= state_d;
            if (take_a) begin
                a_q     <= a_in;
                words_q <= words_in;
                widx_q  <= 10'h000;
                acc_q   <= (a_in.first_seg ? 12'h000 : acc_q) + 12'(a_in.size);
                if (a_in.first_seg) rcv_q <= 12'h000;
            end
            if (take_b) b_q <= b_in;
            if (take_d) begin
                widx_q <= widx_q + 10'h001;
                rcv_q  <= rcv_nx;
            end
        end
    end

    // payload beats: offset and pad dwords carry no lanes and are not sent
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            beat_q <= '0;
        end else begin
            beat_q.valid <= take_d && (lane_ok != 4'h0);
            beat_q.be    <= lane_ok;
            beat_q.data  <= wr_data_i;
            beat_q.last  <= pkt_end; // pad-only final dword gives no last beat
        end
    end

    // per-packet options, taken from the first segment's second word
    wire [15:0] tag_in  = b_in.tag;
    wire        ck_in   = b_in.cksum && a_q.first_seg && ctrl_q;
    wire        crc_in  = !b_in.no_crc || b_in.no_pad;
    wire        pad_in  = !b_in.no_pad;
    wire        start_d = take_b && a_q.first_seg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            info_q  <= '0;
            start_q <= 1'b0;
        end else begin
            start_q <= start_d;
            if (start_d) info_q <= '{tag: tag_in, cksum_en: ck_in,
                                     crc_append: crc_in, pad_en: pad_in};
        end
    end

    // register bus decode; one wait state keeps read data registered
    wire        req    = wb_cyc_i && wb_stb_i && !ack_q;
    wire        wr     = req && wb_we_i && wb_sel_i[0];
    wire        wr_ctl = wr && (wb_adr_i == ADR_CTRL);
    wire        wr_sts = wr && (wb_adr_i == ADR_STATUS);
    wire        wr_msk = wr && (wb_adr_i == ADR_MASK);
    wire [1:0]  ev     = {ev_done, ev_err};
    wire [1:0]  w1c    = wr_sts ? wb_dat_i[1:0] : 2'b00;
    wire [31:0] rsel   = (wb_adr_i == ADR_CTRL)   ? {31'h0, ctrl_q} :
                         (wb_adr_i == ADR_STATUS) ? {30'h0, sts_q} :
                         (wb_adr_i == ADR_MASK)   ? {30'h0, msk_q} :
                         (wb_adr_i == ADR_INFO)   ? {13'h0, info_q} : 32'h0;

    // sticky status: a new event beats a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= 1'b0;
            sts_q  <= 2'b00;
            msk_q  <= 2'b00;
            irq_q  <= 1'b0;
            ack_q  <= 1'b0;
            rdat_q <= 32'h0;
        end else begin
            if (wr_ctl) ctrl_q <= wb_dat_i[CTRL_CKSUM];
            if (wr_msk) msk_q <= wb_dat_i[1:0];
            sts_q  <= (sts_q & ~w1c) | ev;
            irq_q  <= |(sts_q & msk_q);
            ack_q  <= req;
            rdat_q <= req ? rsel : 32'h0;
        end
    end

    assign beat_o      = beat_q;
    assign pkt_info_o  = info_q;
    assign pkt_start_o = start_q;
    assign irq_o       = irq_q;
    assign wb_dat_o    = rdat_q;
    assign wb_ack_o    = ack_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_cksum_gate: assert property (start_d |=> pkt_info_o.cksum_en ==
        ($past(b_in.cksum) && $past(a_q.first_seg) && $past(ctrl_q)))
        else $error("checksum request gated wrongly");
    chk_crc_keep: assert property (start_d && b_in.no_pad |=> pkt_info_o.crc_append)
        else $error("crc dropped while padding suppressed");
    chk_crc_drop: assert property (start_d && b_in.no_crc && !b_in.no_pad
        |=> !pkt_info_o.crc_append)
        else $error("crc kept although suppressed");
    chk_pad_sup: assert property (start_d |=> pkt_info_o.pad_en == !$past(b_in.no_pad))
        else $error("pad enable wrong");
    chk_tag_copy: assert property (start_d |=> pkt_info_o.tag == $past(wr_data_i[31:16]))
        else $error("tag not copied");
    chk_done_set: assert property (buf_end && a_q.ioc |=> sts_q[ST_DONE])
        else $error("done flag not raised");
    chk_len_err: assert property (pkt_end && rcv_nx != len_now |=> sts_q[ST_ERR])
        else $error("length mismatch not flagged");
    chk_sum_err: assert property (pkt_end && acc_q != len_now |=> sts_q[ST_ERR])
        else $error("count sum mismatch not flagged");
    chk_align_err: assert property (bad_align |=> sts_q[ST_ERR])
        else $error("reserved alignment not flagged");
    chk_b_match: assert property (b_diff |=> sts_q[ST_ERR])
        else $error("command b mismatch not flagged");
    chk_offset_skip: assert property (take_d && widx_q == 10'h000 && a_q.offset >= 5'h04
        |=> !beat_o.valid)
        else $error("offset dword forwarded");
    chk_pad_strip: assert property (take_d && b_hi <= {widx_q, 2'b00} |=> !beat_o.valid)
        else $error("pad dword forwarded");
    chk_irq_level: assert property (|(sts_q & msk_q) |=> irq_o)
        else $error("irq not raised");

    // register bus: exactly one registered answer per request
    chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o)
        else $error("request not answered");
    chk_ack_pulse: assert property (wb_ack_o
        |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_rdat_idle: assert property (!wb_ack_o
        |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    chk_ctrl_write: assert property (wr_ctl
        |=> ctrl_q == $past(wb_dat_i[CTRL_CKSUM]))
        else $error("offload enable not written");
    chk_mask_write: assert property (wr_msk
        |=> msk_q == $past(wb_dat_i[1:0]))
        else $error("mask not written");

    // sticky flags: an event beats a clear, otherwise they only move on a write
    chk_err_wins: assert property (wr_sts && wb_dat_i[ST_ERR] && ev_err
        |=> sts_q[ST_ERR])
        else $error("error event lost to clear");
    chk_done_clear: assert property (wr_sts && wb_dat_i[ST_DONE] && !ev_done
        |=> !sts_q[ST_DONE])
        else $error("done flag not cleared");
    chk_err_clear: assert property (wr_sts && wb_dat_i[ST_ERR] && !ev_err
        |=> !sts_q[ST_ERR])
        else $error("error flag not cleared");
    chk_err_hold: assert property (!ev_err && !(wr_sts && wb_dat_i[ST_ERR])
        |=> sts_q[ST_ERR] == $past(sts_q[ST_ERR]))
        else $error("error flag changed by itself");
    chk_done_hold: assert property (!ev_done && !(wr_sts && wb_dat_i[ST_DONE])
        |=> sts_q[ST_DONE] == $past(sts_q[ST_DONE]))
        else $error("done flag changed by itself");
    chk_irq_low: assert property (!(|(sts_q & msk_q))
        |=> !irq_o)
        else $error("irq raised while nothing pending");

    // sequencing: a lost slot would shift every later word of the stream
    chk_state_legal: assert property (1'b1
        |-> state_q inside {ST_CMD_A, ST_CMD_B, ST_DATA})
        else $error("illegal decoder state");
    chk_a_then_b: assert property (take_a
        |=> state_q == ST_CMD_B)
        else $error("command b slot skipped");
    chk_b_to_data: assert property (take_b && words_q != 10'h000
        |=> state_q == ST_DATA)
        else $error("buffer data slot skipped");
    chk_widx_range: assert property (state_q == ST_DATA
        |-> widx_q < words_q)
        else $error("dword index past buffer end");
    chk_b_capture: assert property (take_b
        |=> b_q == $past(b_in))
        else $error("command b not captured");

    // padded length covers offset plus size and ends on the chosen boundary
    chk_words_cover: assert property (take_a
        |=> {words_q, 2'b00} >= b_hi)
        else $error("buffer shorter than its byte count");
    chk_words_tight: assert property (take_a
        |=> {words_q, 2'b00} <= b_hi + AMASK_32)
        else $error("too many pad dwords assumed");
    chk_words_a16: assert property (take_a && a_in.align == ALIGN_16
        |=> ({words_q, 2'b00} & AMASK_16) == 12'h000)
        else $error("16-byte end not kept");
    chk_words_a32: assert property (take_a && a_in.align == ALIGN_32
        |=> ({words_q, 2'b00} & AMASK_32) == 12'h000)
        else $error("32-byte end not kept");

    // payload beats come only from data dwords and carry at least one lane
    chk_beat_src: assert property (!take_d
        |=> !beat_o.valid)
        else $error("beat without a data dword");
    chk_beat_lanes: assert property (beat_o.valid
        |-> beat_o.be != 4'h0)
        else $error("beat with no payload lane");
    chk_last_src: assert property (!pkt_end
        |=> !beat_o.last)
        else $error("last marker off packet end");
    chk_lane_count: assert property (take_d
        |=> rcv_q == $past(rcv_q) + 12'($countones(beat_o.be)))
        else $error("received bytes miscounted");

    // per-packet bookkeeping; options change only at a first segment
    chk_start_pulse: assert property (pkt_start_o
        |=> !pkt_start_o)
        else $error("start held longer than one cycle");
    chk_start_first: assert property (take_b && !a_q.first_seg
        |=> !pkt_start_o)
        else $error("start on a later segment");
    chk_cksum_off: assert property (start_d && !ctrl_q
        |=> !pkt_info_o.cksum_en)
        else $error("checksum without global enable");
    chk_info_hold: assert property (!start_d
        |=> $stable(pkt_info_o))
        else $error("packet options changed mid packet");
    chk_acc_first: assert property (take_a && a_in.first_seg
        |=> acc_q == 12'(a_q.size))
        else $error("count sum not restarted");
    chk_acc_add: assert property (take_a && !a_in.first_seg
        |=> acc_q == $past(acc_q) + 12'(a_q.size))
        else $error("count sum not accumulated");
endmodule : tcw_decoder
`default_nettype wire

// >>> core/tcw_pkg.sv
package tcw_pkg;
    // first command word of a buffer
    typedef struct packed {
        logic        ioc;       // raise done flag at buffer end
        logic [4:0]  rsvd_hi;
        logic [1:0]  align;     // end alignment code
        logic [2:0]  rsvd_mid;
        logic [4:0]  offset;    // data start offset in bytes
        logic [1:0]  rsvd_lo;
        logic        first_seg;
        logic        last_seg;
        logic        rsvd_b11;
        logic [10:0] size;      // buffer byte count
    } tcw_cmd_a_t;

    // second command word, identical for all buffers of a packet
    typedef struct packed {
        logic [15:0] tag;
        logic        rsvd15;
        logic        cksum;     // checksum request
        logic        no_crc;    // suppress frame check sequence unless no_pad is also set
        logic        no_pad;    // suppress short-frame padding
        logic        rsvd11;
        logic [10:0] pkt_len;
    } tcw_cmd_b_t;

    // per-packet options handed to the transmit path
    typedef struct packed {
        logic [15:0] tag;
        logic        cksum_en;
        logic        crc_append;
        logic        pad_en;
    } tcw_info_t;

    // one payload beat with byte lanes
    typedef struct packed {
        logic        valid;
        logic        last;
        logic [3:0]  be;
        logic [31:0] data;
    } tcw_beat_t;

    typedef enum logic [1:0] {
        ST_CMD_A = 2'b00,
        ST_CMD_B = 2'b01,
        ST_DATA  = 2'b10
    } tcw_state_t;

    localparam logic [1:0] ALIGN_4   = 2'h0;
    localparam logic [1:0] ALIGN_16  = 2'h1;
    localparam logic [1:0] ALIGN_32  = 2'h2;
    localparam logic [1:0] ALIGN_BAD = 2'h3;
    localparam logic [11:0] AMASK_4  = 12'h003;
    localparam logic [11:0] AMASK_16 = 12'h00F;
    localparam logic [11:0] AMASK_32 = 12'h01F;

    localparam logic [7:0] ADR_CTRL   = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_MASK   = 8'h08;
    localparam logic [7:0] ADR_INFO   = 8'h0C;

    localparam int ST_ERR  = 0; // status/mask bit: tx_error_flag
    localparam int ST_DONE = 1; // status/mask bit: tx_buffer_done_flag
    localparam int CTRL_CKSUM = 0; // checksum_offload_global_enable
endpackage : tcw_pkg

// >>> sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tcw_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, wv, ack, irq, st;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, wdat, rdat, seed = 32'h61;
    tcw_beat_t beat;
    tcw_info_t info;
    logic [36:0] exp_q[$], e;
    int err_count = 0, n_compared = 0, cycles = 0, n_start = 0;
    always #20 clk_i = ~clk_i;
    tcw_host_model tcw_host_model_i (.clk_i(clk_i), .wr_valid_o(wv), .wr_data_o(wdat));
    tcw_decoder tcw_decoder_i (.clk_i(clk_i), .rst_i(rst_i), .wr_valid_i(wv),
        .wr_data_i(wdat), .beat_o(beat), .pkt_info_o(info), .pkt_start_o(st), .irq_o(irq),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [31:0] lanes(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : lanes
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
            err_count++;
        end
    endtask : chk
    task automatic complete_run();
        if (err_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    // classic cycle, held until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        cyc <= 1'b1; we <= w; adr <= a; wd <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    // expected beats are queued before the buffer goes out
    task automatic buffer(input tcw_cmd_a_t a, input tcw_cmd_b_t b);
        logic [31:0] w[$];
        logic [3:0] be;
        int am, ep, n;
        am = (a.align == ALIGN_16) ? 15 : (a.align == ALIGN_32) ? 31 : 3;
        ep = int'(a.offset) + int'(a.size);
        n = ((ep + am) & ~am) / 4;
        for (int i = 0; i < n; i++) begin
            w.push_back(rnd());
            for (int l = 0; l < 4; l++)
                be[l] = (i * 4 + l >= a.offset) && (i * 4 + l < ep);
            if (be != 4'h0)
                exp_q.push_back({a.last_seg && (i == n - 1), be, w[i] & lanes(be)});
        end
        tcw_host_model_i.send(a, b, w);
        for (int t = 0; t < 200 && exp_q.size() != 0; t++)
            @(posedge clk_i);
        repeat (3) @(posedge clk_i);
        chk("beats pending", 32'h0, 32'(exp_q.size()));
        exp_q.delete();
    endtask : buffer
    // each beat is matched to the oldest note; also the hang guard
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles > 20000) begin
            err_count++;
            complete_run();
        end
        if (!rst_i && st !== 1'b0)
            n_start <= n_start + 1;
        if (!rst_i && beat.valid !== 1'b0) begin
            e = (exp_q.size() != 0) ? exp_q.pop_front() : 37'h0;
            chk("beat lanes", {27'h0, e[36:32]}, {27'h0, beat.last, beat.be});
            chk("beat data", e[31:0], beat.data & lanes(beat.be));
        end
    end
    initial begin
        tcw_cmd_a_t a;
        tcw_cmd_b_t b, b2;
        logic [31:0] r;
        int s2;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b1, ADR_MASK, 32'h3, r);
        wb(1'b1, ADR_CTRL, 32'h1, r);
        for (int k = 0; k < 4; k++) begin
            a = '0; b = rnd();
            a.ioc = 1'b1; a.first_seg = 1'b1; a.last_seg = 1'b1; a.align = k[1:0];
            a.offset = (k == 0) ? 5'h1F : 5'(rnd());
            a.size = 11'(rnd() % 40 + 1);
            b.pkt_len = a.size; b.cksum = 1'b1; b.no_crc = k[0]; b.no_pad = k[1];
            buffer(a, b);
            wb(1'b0, ADR_STATUS, 32'h0, r);
            chk("status", {30'h0, 1'b1, k == 3}, r);
            chk("irq", 32'h1, {31'h0, irq});
            chk("start count", 32'(k + 1), 32'(n_start));
            wb(1'b0, ADR_INFO, 32'h0, r);
            chk("info", {13'h0, b.tag, 1'b1, !k[0] | k[1], !k[1]}, r);
            wb(1'b1, ADR_STATUS, 32'h3, r);
            wb(1'b0, ADR_STATUS, 32'h0, r);
            chk("cleared", 32'h0, r);
            chk("irq cleared", 32'h0, {31'h0, irq});
        end
        wb(1'b1, ADR_CTRL, 32'h0, r);
        wb(1'b1, ADR_MASK, 32'h1, r);
        for (int m = 0; m < 3; m++) begin
            a = '0; b = rnd(); s2 = rnd() % 30 + 4;
            a.first_seg = 1'b1; a.offset = 5'(rnd()); a.size = 11'(rnd() % 30 + 4);
            b.cksum = 1'b1; b.pkt_len = 11'(int'(a.size) + s2 + (m == 1));
            buffer(a, b);
            b2 = b;
            if (m == 2) b2.tag = ~b.tag;
            a.first_seg = 1'b0; a.last_seg = 1'b1; a.ioc = 1'b1;
            a.offset = 5'(rnd()); a.size = 11'(s2);
            buffer(a, b2);
            wb(1'b0, ADR_STATUS, 32'h0, r);
            chk("packet status", {30'h0, 1'b1, m != 0}, r);
            chk("masked irq", {31'h0, m != 0}, {31'h0, irq});
            chk("info tag", {16'h0, b.tag}, {16'h0, info.tag});
            chk("cksum off", 32'h0, {31'h0, info.cksum_en});
            chk("start count", 32'(m + 5), 32'(n_start));
            wb(1'b1, ADR_STATUS, 32'h3, r);
        end
        wb(1'b0, 8'h10, 32'h0, r);
        chk("unmapped", 32'h0, r);
        complete_run();
    end
endmodule : tb
`default_nettype wire

// >>> sim/tcw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host writer feeding command words and buffer dwords into the word stream
module tcw_host_model (
    input  wire logic        clk_i,
    output logic             wr_valid_o,
    output logic [31:0]      wr_data_o
);
    import tcw_pkg::*;
    initial begin
        wr_valid_o = 1'b0;
        wr_data_o  = 32'h0;
    end
    // valid stays up across a buffer so no edge sees two writes of it
    task automatic send(input tcw_cmd_a_t a, input tcw_cmd_b_t b, input logic [31:0] w[$]);
        a.rsvd_hi  = 5'h0;
        a.rsvd_mid = 3'h0;
        a.rsvd_lo  = 2'h0;
        a.rsvd_b11 = 1'b0;
        b.rsvd15   = 1'b0;
        b.rsvd11   = 1'b0;
        w.push_front(b);
        w.push_front(a);
        foreach (w[i]) begin
            wr_valid_o <= 1'b1;
            wr_data_o  <= w[i];
            @(posedge clk_i);
        end
        // released data flips so a stale word never looks fresh
        wr_valid_o <= 1'b0;
        wr_data_o  <= ~wr_data_o;
    endtask : send
endmodule : tcw_host_model
`default_nettype wire
